// ---- hw/prg_pkg.sv ----
// constants for the physical random generator with health gating
package prg_pkg;
    // total-failure test: longest tolerated run of equal raw bits
    localparam int STUCK_RUN = 32;
    localparam int RUN_W = 6;
    // online test window and acceptance band for the count of ones
    localparam int WIN_LEN = 256;
    localparam int WIN_W = 9;
    localparam logic [8:0] ONES_LO = 9'h060;
    localparam logic [8:0] ONES_HI = 9'h0A0;
    // gap between windows in periodic mode
    localparam int GAP_NS = 20480;
    localparam int CLK_NS = 20;
    localparam int GAP_CYC = GAP_NS / CLK_NS;
    localparam int GAP_W = 11;
    // software-started hardware self test length in raw bits
    localparam int SELF_LEN = 64;
    localparam int SELF_W = 7;
    // online test trigger options
    localparam logic MODE_PERIODIC = 1'b0;
    localparam logic MODE_CONTINUOUS = 1'b1;
    localparam logic [7:0] OCTET_RST = 8'h00;
    // generator states
    typedef enum logic [1:0] {
        PRG_IDLE = 2'b00,
        PRG_STARTUP = 2'b01,
        PRG_RUN = 2'b10,
        PRG_FAILED = 2'b11
    } prg_state_t;
endpackage

// ---- hw/prg_health_gate.sv ----
// random generator core with total-failure and online health gating
`timescale 1ns/1ps
module prg_health_gate #(
    parameter int GAP_CYCLES = prg_pkg::GAP_CYC,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // entropy source, asynchronous
    input wire logic rawBit,
    // software control
    input wire logic rngEnable,
    input wire logic testMode,
    input wire logic startTest,
    input wire logic dataTaken,
    // random data to software
    output logic [7:0] rngData,
    output logic rngValid,
    // health status to software
    output logic totalFail,
    output logic defect,
    output logic testBusy,
    output logic testPass,
    output logic testFail,
    // pre-delivery nonvolatile write path
    input wire logic preDelivery,
    input wire logic progWr,
    input wire logic [ADDR_W-1:0] progAddr,
    input wire logic [7:0] progData,
    output logic nvmWrEn,
    output logic [ADDR_W-1:0] nvmAddr,
    output logic [7:0] nvmData
);
    localparam int GAP_W_L = prg_pkg::GAP_W;
    localparam logic [prg_pkg::WIN_W-1:0] ONES_LO_L = prg_pkg::ONES_LO;
    localparam logic [prg_pkg::WIN_W-1:0] ONES_HI_L = prg_pkg::ONES_HI;
    prg_pkg::prg_state_t state_r, state_nxt;
    logic sync1_r, sync2_r, prevBit_r;
    logic [prg_pkg::RUN_W-1:0] runCnt_r;
    logic winActive_r;
    logic [prg_pkg::WIN_W-1:0] winCnt_r, onesCnt_r;
    logic [GAP_W_L-1:0] gapCnt_r;
    logic pairPhase_r, pairBit_r;
    logic [7:0] shift_r, cand_r, rngData_r;
    logic [2:0] bitCnt_r;
    logic candValid_r, rngValid_r, totalFail_r, defect_r;
    logic testBusy_r, testPass_r, testFail_r, selfOne_r, selfZero_r, selfStuck_r;
    logic [prg_pkg::SELF_W-1:0] selfCnt_r;
    logic nvmWrEn_r;
    logic [ADDR_W-1:0] nvmAddr_r;
    logic [7:0] nvmData_r;

    // decode
    wire logic active = (state_r == prg_pkg::PRG_STARTUP) || (state_r == prg_pkg::PRG_RUN);
    wire logic sameBit = (sync2_r == prevBit_r);
    wire logic runFull = (runCnt_r == prg_pkg::RUN_W'(prg_pkg::STUCK_RUN - 1));
    wire logic stuck = active && sameBit && runFull;
    wire logic winLast = winActive_r && (winCnt_r == prg_pkg::WIN_W'(prg_pkg::WIN_LEN - 1));
    wire logic [prg_pkg::WIN_W-1:0] onesFinal = onesCnt_r + prg_pkg::WIN_W'(sync2_r);
    wire logic winBad = winLast && ((onesFinal < ONES_LO_L) || (onesFinal > ONES_HI_L));
    wire logic gapDone = (testMode == prg_pkg::MODE_CONTINUOUS)
        || (gapCnt_r == GAP_W_L'(GAP_CYCLES - 1));
    // start-up window opens at once, the gap applies only while running
    wire logic winStart = active && !winActive_r
        && (gapDone || (state_r == prg_pkg::PRG_STARTUP));
    wire logic octetDone = pairPhase_r && (bitCnt_r == 3'h7);
    wire logic internalBit = pairBit_r ^ sync2_r;
    wire logic promote = candValid_r && !sameBit && (state_r == prg_pkg::PRG_RUN)
        && !stuck && !winBad && !rngValid_r;
    wire logic selfLast = testBusy_r && (selfCnt_r == prg_pkg::SELF_W'(prg_pkg::SELF_LEN - 1));
    wire logic selfBad = selfStuck_r || stuck || !(selfOne_r || sync2_r)
        || !(selfZero_r || !sync2_r);

    // state sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            prg_pkg::PRG_IDLE: begin
                if (rngEnable) begin
                    state_nxt = prg_pkg::PRG_STARTUP;
                end
            end
            prg_pkg::PRG_STARTUP: begin
                if (stuck || winBad) begin
                    state_nxt = prg_pkg::PRG_FAILED;
                end else if (winLast) begin
                    state_nxt = prg_pkg::PRG_RUN;
                end
            end
            prg_pkg::PRG_RUN: begin
                if (stuck || winBad) begin
                    state_nxt = prg_pkg::PRG_FAILED;
                end
            end
            prg_pkg::PRG_FAILED: begin
                state_nxt = prg_pkg::PRG_FAILED;
            end
            default: begin
                state_nxt = prg_pkg::PRG_IDLE;
            end
        endcase
        if (!rngEnable) begin
            state_nxt = prg_pkg::PRG_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= prg_pkg::PRG_IDLE;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prevBit_r <= 1'b0;
            runCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            sync1_r <= rawBit;
            sync2_r <= sync1_r;
            prevBit_r <= sync2_r;
            runCnt_r <= (sameBit && !stuck) ? runCnt_r + 1'b1 : '0;
        end
    end

    // online test windows
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            winActive_r <= 1'b0;
            winCnt_r <= '0;
            onesCnt_r <= '0;
            gapCnt_r <= '0;
        end else if (!active) begin
            winActive_r <= 1'b0;
            winCnt_r <= '0;
            onesCnt_r <= '0;
            gapCnt_r <= '0;
        end else if (winStart) begin
            winActive_r <= 1'b1;
            winCnt_r <= '0;
            onesCnt_r <= '0;
            gapCnt_r <= '0;
        end else if (winActive_r) begin
            winActive_r <= !winLast;
            winCnt_r <= winCnt_r + 1'b1;
            onesCnt_r <= onesFinal;
        end else begin
            gapCnt_r <= gapCnt_r + 1'b1;
        end
    end

    // octet assembly; each internal bit folds two raw bits to cut bias
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pairPhase_r <= 1'b0;
            pairBit_r <= 1'b0;
            shift_r <= prg_pkg::OCTET_RST;
            bitCnt_r <= 3'h0;
            cand_r <= prg_pkg::OCTET_RST;
            candValid_r <= 1'b0;
        end else if (state_r != prg_pkg::PRG_RUN || stuck) begin
            pairPhase_r <= 1'b0;
            bitCnt_r <= 3'h0;
            candValid_r <= 1'b0;
        end else begin
            pairPhase_r <= !pairPhase_r;
            pairBit_r <= sync2_r;
            if (pairPhase_r) begin
                shift_r <= {shift_r[6:0], internalBit};
                bitCnt_r <= bitCnt_r + 1'b1;
            end
            if (octetDone) begin
                cand_r <= {shift_r[6:0], internalBit};
                candValid_r <= 1'b1;
            end else if (promote) begin
                candValid_r <= 1'b0;
            end
        end
    end

    // software-facing data and status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rngData_r <= prg_pkg::OCTET_RST;
            rngValid_r <= 1'b0;
            totalFail_r <= 1'b0;
            defect_r <= 1'b0;
        end else begin
            if (promote) begin
                rngData_r <= cand_r;
                rngValid_r <= 1'b1;
            end else if (dataTaken || state_r != prg_pkg::PRG_RUN || stuck || winBad) begin
                rngValid_r <= 1'b0;
            end
            if (state_r == prg_pkg::PRG_IDLE && rngEnable) begin
                totalFail_r <= 1'b0;
                defect_r <= 1'b0;
            end else begin
                totalFail_r <= totalFail_r | stuck;
                defect_r <= defect_r | (active && winBad);
            end
        end
    end

    // software-started hardware total-failure test
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            testBusy_r <= 1'b0;
            testPass_r <= 1'b0;
            testFail_r <= 1'b0;
            selfCnt_r <= '0;
            selfOne_r <= 1'b0;
            selfZero_r <= 1'b0;
            selfStuck_r <= 1'b0;
        end else if (startTest && !testBusy_r) begin
            testBusy_r <= 1'b1;
            testPass_r <= 1'b0;
            testFail_r <= 1'b0;
            selfCnt_r <= '0;
            selfOne_r <= 1'b0;
            selfZero_r <= 1'b0;
            selfStuck_r <= 1'b0;
        end else if (testBusy_r) begin
            selfCnt_r <= selfCnt_r + 1'b1;
            selfOne_r <= selfOne_r | sync2_r;
            selfZero_r <= selfZero_r | !sync2_r;
            selfStuck_r <= selfStuck_r | (sameBit && runFull);
            if (selfLast) begin
                testBusy_r <= 1'b0;
                testPass_r <= !selfBad;
                testFail_r <= selfBad;
            end
        end
    end

    // pre-delivery nonvolatile write forwarding
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nvmWrEn_r <= 1'b0;
            nvmAddr_r <= '0;
            nvmData_r <= 8'h00;
        end else begin
            nvmWrEn_r <= preDelivery && progWr;
            if (preDelivery && progWr) begin
                nvmAddr_r <= progAddr;
                nvmData_r <= progData;
            end
        end
    end

    assign rngData = rngData_r;
    assign rngValid = rngValid_r;
    assign totalFail = totalFail_r;
    assign defect = defect_r;
    assign testBusy = testBusy_r;
    assign testPass = testPass_r;
    assign testFail = testFail_r;
    assign nvmWrEn = nvmWrEn_r;
    assign nvmAddr = nvmAddr_r;
    assign nvmData = nvmData_r;

    property p_stuck_fails;
        @(posedge sys_clk) disable iff (!rst_n)
        stuck && rngEnable |=> state_r == prg_pkg::PRG_FAILED && totalFail_r;
    endproperty
    a_stuck_fails: assert property (p_stuck_fails) else $error("stuck source not flagged");

    property p_no_out_failed;
        @(posedge sys_clk) disable iff (!rst_n)
        state_r == prg_pkg::PRG_FAILED |-> !rngValid_r;
    endproperty
    a_no_out_failed: assert property (p_no_out_failed) else $error("output after failure");

    property p_promote_after_edge;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rngValid_r) |-> $past(sync2_r) != $past(prevBit_r);
    endproperty
    a_promote_after_edge: assert property (p_promote_after_edge) else $error("octet released early");

    property p_defect_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        active && winBad && rngEnable |=> defect_r && state_r == prg_pkg::PRG_FAILED;
    endproperty
    a_defect_flag: assert property (p_defect_flag) else $error("defect not flagged");

    property p_no_out_startup;
        @(posedge sys_clk) disable iff (!rst_n)
        state_r != prg_pkg::PRG_RUN |=> !rngValid_r;
    endproperty
    a_no_out_startup: assert property (p_no_out_startup) else $error("output before pass");

    property p_continuous;
        @(posedge sys_clk) disable iff (!rst_n)
        winLast && testMode == prg_pkg::MODE_CONTINUOUS && state_r == prg_pkg::PRG_RUN
            && !winBad && !stuck && rngEnable ##1 testMode == prg_pkg::MODE_CONTINUOUS
            |=> winActive_r;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous test stalled");

    property p_self_result;
        @(posedge sys_clk) disable iff (!rst_n)
        startTest && !testBusy_r |=> testBusy_r ##64 !testBusy_r && (testPass_r != testFail_r);
    endproperty
    a_self_result: assert property (p_self_result) else $error("self test result missing");

    property p_nvm_write;
        @(posedge sys_clk) disable iff (!rst_n)
        preDelivery && progWr |=> nvmWrEn_r && nvmData_r == $past(progData);
    endproperty
    a_nvm_write: assert property (p_nvm_write) else $error("nvm write lost");

    property p_taken_clears;
        @(posedge sys_clk) disable iff (!rst_n)
        rngValid_r && dataTaken && !promote |=> !rngValid_r;
    endproperty
    a_taken_clears: assert property (p_taken_clears) else $error("valid not cleared");
endmodule

// ---- verification/prg_health_gate_tb.sv ----
// self-checking bench for the health-gated random generator
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rawBit = 1'b0;
    logic rngEnable = 1'b0;
    logic testMode = 1'b0;
    logic startTest = 1'b0;
    logic dataTaken = 1'b0;
    logic preDelivery = 1'b0;
    logic progWr = 1'b0;
    logic [15:0] progAddr = 16'h0000;
    logic [7:0] progData = 8'h00;
    logic [7:0] rngData;
    logic rngValid, totalFail, defect, testBusy, testPass, testFail, nvmWrEn;
    logic [15:0] nvmAddr;
    logic [7:0] nvmData;
    int err_total = 0;
    int n_compared = 0;
    // raw source: 0 lfsr, 1 stuck high, 2 sparse ones, 3 alternating
    int srcKind = 0;
    logic [7:0] lfsr = 8'h01;
    logic [1:0] sparse = 2'b00;

    always #10 sys_clk = ~sys_clk;

    always @(negedge sys_clk) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        sparse <= sparse + 2'b01;
        rawBit <= (srcKind == 0) ? lfsr[0] : ((srcKind == 1) ? 1'b1
            : ((srcKind == 2) ? (sparse == 2'b00) : sparse[0]));
    end

    prg_health_gate #(.GAP_CYCLES(16), .ADDR_W(16)) u_prg_health_gate (
        .sys_clk(sys_clk), .rst_n(rst_n), .rawBit(rawBit), .rngEnable(rngEnable),
        .testMode(testMode), .startTest(startTest), .dataTaken(dataTaken),
        .rngData(rngData), .rngValid(rngValid), .totalFail(totalFail), .defect(defect),
        .testBusy(testBusy), .testPass(testPass), .testFail(testFail),
        .preDelivery(preDelivery), .progWr(progWr), .progAddr(progAddr),
        .progData(progData), .nvmWrEn(nvmWrEn), .nvmAddr(nvmAddr), .nvmData(nvmData)
    );

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = rngValid;
            1: pick = totalFail;
            2: pick = defect;
            default: pick = testPass | testFail;
        endcase
    endfunction

    // bounded wait for a status output to go high
    task automatic wait_hi(input int sel, input int bound, input string what);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < bound && !hit; i++) begin
            @(negedge sys_clk);
            hit = (pick(sel) === 1'b1);
        end
        if (!hit) begin
            err_total++;
            $display("FAIL wait %s expected 1 seen 0", what);
            report_and_stop();
        end
    endtask

    task automatic restart(input int src);
        rngEnable = 1'b0;
        repeat (3) @(negedge sys_clk);
        srcKind = src;
        rngEnable = 1'b1;
    endtask

    task automatic take_octet();
        dataTaken = 1'b1;
        @(negedge sys_clk);
        dataTaken = 1'b0;
        chk_bit("rngValid after take", 1'b0, rngValid);
    endtask

    task automatic t_startup();
        int early;
        early = 0;
        restart(0);
        repeat (272) begin
            @(negedge sys_clk);
            early += (rngValid !== 1'b0);
        end
        chk_vec("octets before start-up pass", 16'h0000, 16'(early));
        wait_hi(0, 300, "first octet");
        repeat (5) @(negedge sys_clk);
        chk_bit("rngValid held", 1'b1, rngValid);
        chk_bit("no defect on good source", 1'b0, defect);
        take_octet();
        $display("test startup done");
    endtask

    task automatic t_stuck();
        int leak;
        leak = 0;
        restart(0);
        wait_hi(0, 600, "octet before stuck");
        take_octet();
        srcKind = 1;
        wait_hi(1, 40, "totalFail");
        chk_bit("rngValid at failure", 1'b0, rngValid);
        repeat (100) begin
            @(negedge sys_clk);
            leak += (rngValid !== 1'b0);
        end
        chk_vec("octets after failure", 16'h0000, 16'(leak));
        chk_bit("totalFail sticky", 1'b1, totalFail);
        restart(0);
        repeat (4) @(negedge sys_clk);
        chk_bit("totalFail cleared on restart", 1'b0, totalFail);
        $display("test stuck done");
    endtask

    task automatic t_defect();
        restart(2);
        wait_hi(2, 400, "start-up defect");
        chk_bit("rngValid with start-up defect", 1'b0, rngValid);
        for (int m = 0; m < 2; m++) begin
            testMode = (m == 0) ? prg_pkg::MODE_PERIODIC : prg_pkg::MODE_CONTINUOUS;
            restart(0);
            wait_hi(0, 600, "octet before defect");
            take_octet();
            srcKind = 2;
            wait_hi(2, 1000, "running defect");
            chk_bit("rngValid after defect", 1'b0, rngValid);
            chk_bit("no total failure", 1'b0, totalFail);
        end
        $display("test defect done");
    endtask

    // alternating raw bits fold to all-ones octets whatever the pair phase
    task automatic t_pattern();
        testMode = prg_pkg::MODE_CONTINUOUS;
        restart(3);
        wait_hi(0, 600, "pattern octet");
        chk_vec("rngData alternating source", 16'h00FF, {8'h00, rngData});
        take_octet();
        repeat (300) @(negedge sys_clk);
        chk_bit("no defect after running window", 1'b0, defect);
        chk_bit("octet after running window", 1'b1, rngValid);
        chk_vec("rngData second octet", 16'h00FF, {8'h00, rngData});
        $display("test pattern done");
    endtask

    task automatic t_selftest();
        int n;
        rngEnable = 1'b0;
        for (int s = 0; s < 2; s++) begin
            srcKind = s;
            repeat (40) @(negedge sys_clk);
            startTest = 1'b1;
            @(negedge sys_clk);
            startTest = 1'b0;
            chk_bit("testBusy after start", 1'b1, testBusy);
            n = 1;
            while (testBusy === 1'b1 && n < 80) begin
                @(negedge sys_clk);
                n += (testBusy === 1'b1);
            end
            chk_bit("busy length", 1'b1, n >= 64 && n <= 66);
            chk_bit("testPass", (s == 0), testPass);
            chk_bit("testFail", (s == 1), testFail);
        end
        $display("test selftest done");
    endtask

    task automatic t_nvm();
        preDelivery = 1'b1;
        progWr = 1'b1;
        progAddr = 16'h1234;
        progData = 8'hA5;
        @(negedge sys_clk);
        chk_bit("nvmWrEn first", 1'b1, nvmWrEn);
        chk_vec("nvmAddr first", 16'h1234, nvmAddr);
        chk_vec("nvmData first", 16'h00A5, {8'h00, nvmData});
        progAddr = 16'hFFFF;
        progData = 8'h5A;
        @(negedge sys_clk);
        progWr = 1'b0;
        chk_vec("nvmAddr second", 16'hFFFF, nvmAddr);
        chk_vec("nvmData second", 16'h005A, {8'h00, nvmData});
        @(negedge sys_clk);
        chk_bit("nvmWrEn pulse ends", 1'b0, nvmWrEn);
        preDelivery = 1'b0;
        progWr = 1'b1;
        progAddr = 16'h0001;
        @(negedge sys_clk);
        chk_bit("nvmWrEn outside pre-delivery", 1'b0, nvmWrEn);
        progWr = 1'b0;
        @(negedge sys_clk);
        chk_vec("nvmAddr held", 16'hFFFF, nvmAddr);
        $display("test nvm done");
    endtask

    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        chk_vec("outputs after reset", 16'h0000,
            {rngValid, totalFail, defect, testBusy, testPass, testFail, nvmWrEn, 9'h000});
        chk_vec("rngData after reset", 16'h0000, {8'h00, rngData});
        t_startup();
        t_stuck();
        t_defect();
        t_pattern();
        t_selftest();
        t_nvm();
        report_and_stop();
    end
endmodule
